// File: rtl/windowed_watchdog_pkg.sv
package windowed_watchdog_pkg;

  // clock rates; the system and MF rates are used for the oscillator sampling check
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned LF_OSC_HZ = 31_000;
  localparam int unsigned MF_OSC_HZ = 31_250;
  localparam int unsigned OSC_OVERSAMPLE = 4;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_CTRL0 = 14'h0ecd;
  localparam logic [13:0] IDX_CTRL1 = 14'h0ece;
  localparam logic [13:0] IDX_PSL   = 14'h0ecf;
  localparam logic [13:0] IDX_PSH   = 14'h0ed0;
  localparam logic [13:0] IDX_TMR   = 14'h0ed1;
  localparam logic [13:0] IDX_FLAGS = 14'h0ed2;

  // field positions
  localparam int unsigned C0_SWEN_BIT = 0;
  localparam int unsigned C0_PS_LSB  = 1;
  localparam int unsigned C1_WIN_LSB = 0;
  localparam int unsigned C1_CS_LSB  = 4;
  localparam int unsigned FL_WV_BIT  = 0;
  localparam int unsigned FL_RW_BIT  = 1;
  localparam int unsigned FL_TO_BIT  = 2;
  localparam int unsigned FL_PWRDN_BIT = 3;

  // counter geometry
  localparam int unsigned PS_CNT_W = 18;
  localparam int unsigned TMR_W    = 5;
  localparam logic [4:0]  TMR_LAST = 5'h1f;

  // operating modes
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_SW    = 2'h1;
  localparam logic [1:0] MODE_NOSLP = 2'h2;
  localparam logic [1:0] MODE_ON    = 2'h3;

  // codes and reset values
  localparam logic [4:0] PS_RST     = 5'h0b;
  localparam logic [4:0] PS_MAX     = 5'h12;
  localparam logic [4:0] PS_MIN     = 5'h00;
  localparam logic [4:0] PS_CFG_SW  = 5'h1f;
  localparam logic [2:0] CS_RST     = 3'h0;
  localparam logic [2:0] CS_MF      = 3'h1;
  localparam logic [2:0] CS_CFG_SW  = 3'h7;
  localparam logic [2:0] WIN_RST    = 3'h7;
  localparam logic [2:0] WIN_FULL   = 3'h7;
  localparam logic [2:0] WIN_CFG_SW = 3'h7;

  // configuration-word settings
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] cs;
    logic [4:0] ps;
    logic [2:0] win;
  } windowed_watchdog_cfg_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } windowed_watchdog_apb_t;

endpackage : windowed_watchdog_pkg

// File: rtl/windowed_watchdog_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_top #(
  parameter int unsigned CLK_HZ = windowed_watchdog_pkg::CLK_HZ
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic                dev_rst,
  input  wire windowed_watchdog_pkg::windowed_watchdog_cfg_t cfg,
  input  wire logic                lf_osc_clk,
  input  wire logic                mf_osc_clk,
  input  wire logic                in_sleep,
  input  wire logic                startup_busy,
  input  wire logic                clear_instr,
  input  wire windowed_watchdog_pkg::windowed_watchdog_apb_t apb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     wdt_reset_req,
  output logic                     wake_req,
  output logic                     timeout_status_n,
  output logic                     powerdown_status_n,
  output logic                     window_violation_flag,
  output logic                     watchdog_reset_flag
);

  localparam int unsigned PW = windowed_watchdog_pkg::PS_CNT_W;

  // oscillators must be sampled well above their rate
  if (CLK_HZ < windowed_watchdog_pkg::OSC_OVERSAMPLE * windowed_watchdog_pkg::MF_OSC_HZ) begin : g_chk
    $error("system clock too slow to sample the watchdog oscillators");
  end

  // all state of the block
  typedef struct packed {
    logic                      lf_s1;
    logic                      lf_s2;
    logic                      lf_s3;
    logic                      mf_s1;
    logic                      mf_s2;
    logic                      mf_s3;
    logic                      sleep_d;
    logic                      sw_en;
    logic [4:0]                ps_fld;
    logic [2:0]                cs_fld;
    logic [2:0]                win_fld;
    logic                      armed;
    logic [PW-1:0]             pre_cnt;
    logic [windowed_watchdog_pkg::TMR_W-1:0] tmr;
    logic                      wv_flag;
    logic                      rw_flag;
    logic                      to_n;
    logic                      pwrdn_n;
    logic                      rst_req;
    logic                      wake;
    logic [31:0]               rdata;
  } windowed_watchdog_state_t;

  localparam windowed_watchdog_state_t ST_RST = '{
    ps_fld:  windowed_watchdog_pkg::PS_RST,
    cs_fld:  windowed_watchdog_pkg::CS_RST,
    win_fld: windowed_watchdog_pkg::WIN_RST,
    wv_flag: 1'b1,
    rw_flag: 1'b1,
    to_n:    1'b1,
    pwrdn_n: 1'b1,
    default: '0
  };

  windowed_watchdog_state_t st;
  windowed_watchdog_state_t next_st;

  logic [4:0]    ps_eff;
  logic [4:0]    ps_use;
  logic [2:0]    cs_eff;
  logic [2:0]    win_eff;
  logic [4:0]    thr;
  logic [PW:0]   ps_lim;
  logic          active;
  logic          tick;
  logic          pre_done;
  logic          tout;
  logic          windowed;
  logic          win_open;
  logic          viol;
  logic          valid_clr;
  logic          sleep_enter;
  logic          sleep_exit;
  logic          cnt_clr;
  logic          acc;
  logic          setup;
  logic [13:0]   idx;
  logic          sel_c0;
  logic          sel_c1;
  logic          sel_psl;
  logic          sel_psh;
  logic          sel_tmr;
  logic          sel_fl;
  logic          hit;
  logic          ctrl_wr;
  logic          wr_lane;
  logic          rd_c0;
  logic [31:0]   rd_val;

  // effective settings: config word locks a field unless all ones; clock source is locked only in modes 10 and 11
  // prescale source
  assign ps_eff = (cfg.ps == windowed_watchdog_pkg::PS_CFG_SW) ? st.ps_fld : cfg.ps;
  assign ps_use = (ps_eff > windowed_watchdog_pkg::PS_MAX) ? windowed_watchdog_pkg::PS_MIN : ps_eff;
  assign cs_eff = (cfg.mode[1] && cfg.cs != windowed_watchdog_pkg::CS_CFG_SW) ? cfg.cs : st.cs_fld;
  assign win_eff = (cfg.win == windowed_watchdog_pkg::WIN_CFG_SW) ? st.win_fld : cfg.win;

  // operating mode decode
  always_comb begin
    unique case (cfg.mode)
      windowed_watchdog_pkg::MODE_ON:    active = 1'b1;
      windowed_watchdog_pkg::MODE_NOSLP: active = ~in_sleep;
      windowed_watchdog_pkg::MODE_SW:    active = st.sw_en;
      windowed_watchdog_pkg::MODE_OFF:   active = 1'b0;
    endcase
  end

  // watchdog clock edge from the selected oscillator
  assign tick = (cs_eff == windowed_watchdog_pkg::CS_MF) ? (st.mf_s2 & ~st.mf_s3)
                                            : (st.lf_s2 & ~st.lf_s3);

  // prescaler wraps after 2^code ticks, codes above 18 acting as code 0, 32 wraps per period
  assign ps_lim   = {{PW{1'b0}}, 1'b1} << ps_use;
  assign pre_done = (({1'b0, st.pre_cnt} + 1'b1) == ps_lim);
  assign tout     = active & tick & pre_done & (st.tmr == windowed_watchdog_pkg::TMR_LAST);

  // threshold is 4 * (7 - code); code 111 gives zero
  assign thr      = {~win_eff, 2'b00};
  assign windowed = (win_eff != windowed_watchdog_pkg::WIN_FULL);
  assign win_open = (st.tmr >= thr);

  // clear outside window or without arming
  assign viol      = clear_instr & active & windowed & (~st.armed | ~win_open);
  // only an armed clear is accepted in windowed mode
  assign valid_clr = clear_instr & active & ~viol;

  assign sleep_enter = in_sleep & ~st.sleep_d;
  assign sleep_exit  = ~in_sleep & st.sleep_d;

  // apb decode, zero wait states
  assign acc     = apb.psel & apb.penable;
  assign setup   = apb.psel & ~apb.penable;
  assign idx     = apb.paddr[15:2];
  assign sel_c0  = (idx == windowed_watchdog_pkg::IDX_CTRL0);
  assign sel_c1  = (idx == windowed_watchdog_pkg::IDX_CTRL1);
  assign sel_psl = (idx == windowed_watchdog_pkg::IDX_PSL);
  assign sel_psh = (idx == windowed_watchdog_pkg::IDX_PSH);
  assign sel_tmr = (idx == windowed_watchdog_pkg::IDX_TMR);
  assign sel_fl  = (idx == windowed_watchdog_pkg::IDX_FLAGS);
  assign hit     = sel_c0 | sel_c1 | sel_psl | sel_psh | sel_tmr | sel_fl;
  assign ctrl_wr = acc & apb.pwrite & (sel_c0 | sel_c1);
  assign wr_lane = acc & apb.pwrite & apb.pstrb[0];
  assign rd_c0   = acc & ~apb.pwrite & sel_c0;

  // every cause that clears the counter
  assign cnt_clr = dev_rst | valid_clr | sleep_enter | sleep_exit | ~active
                 | startup_busy | ctrl_wr | tout | viol;

  // read data mux, captured in the setup phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (sel_c0) begin
      rd_val[windowed_watchdog_pkg::C0_SWEN_BIT] = st.sw_en;
      rd_val[windowed_watchdog_pkg::C0_PS_LSB +: 5] = ps_eff;
    end
    if (sel_c1) begin
      rd_val[windowed_watchdog_pkg::C1_CS_LSB +: 3] = cs_eff;
      rd_val[windowed_watchdog_pkg::C1_WIN_LSB +: 3] = win_eff;
    end
    if (sel_psl) begin
      rd_val[7:0] = st.pre_cnt[7:0];
    end
    if (sel_psh) begin
      rd_val[7:0] = st.pre_cnt[15:8];
    end
    // armed status in the counter register
    if (sel_tmr) begin
      rd_val[7:0] = {st.tmr, st.armed, st.pre_cnt[PW-1:PW-2]};
    end
    if (sel_fl) begin
      rd_val[windowed_watchdog_pkg::FL_WV_BIT] = st.wv_flag;
      rd_val[windowed_watchdog_pkg::FL_RW_BIT] = st.rw_flag;
      rd_val[windowed_watchdog_pkg::FL_TO_BIT] = st.to_n;
      rd_val[windowed_watchdog_pkg::FL_PWRDN_BIT] = st.pwrdn_n;
    end
  end

  // next state of the whole block
  always_comb begin
    next_st = st;
    // oscillator synchronisers and edge stage
    next_st.lf_s1 = lf_osc_clk;
    next_st.lf_s2 = st.lf_s1;
    next_st.lf_s3 = st.lf_s2;
    next_st.mf_s1 = mf_osc_clk;
    next_st.mf_s2 = st.mf_s1;
    next_st.mf_s3 = st.mf_s2;
    next_st.sleep_d = in_sleep;

    next_st.rst_req = (tout & ~in_sleep) | viol;
    next_st.wake    = tout & in_sleep;

    if (cnt_clr) begin
      next_st.pre_cnt = '0;
      next_st.tmr     = '0;
      next_st.armed   = 1'b0;
    // count on each rising watchdog clock edge
    end else if (tick) begin
      if (pre_done) begin
        next_st.pre_cnt = '0;
        next_st.tmr     = st.tmr + 1'b1;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 1'b1;
      end
    end
    // no divider input reaches the counter

    if (rd_c0) begin
      next_st.armed = 1'b1;
    end

    // register writes, locked fields ignored
    if (wr_lane && sel_c0) begin
      next_st.sw_en = apb.pwdata[windowed_watchdog_pkg::C0_SWEN_BIT];
      if (cfg.ps == windowed_watchdog_pkg::PS_CFG_SW) begin
        next_st.ps_fld = apb.pwdata[windowed_watchdog_pkg::C0_PS_LSB +: 5];
      end
    end
    if (wr_lane && sel_c1) begin
      if (cfg.cs == windowed_watchdog_pkg::CS_CFG_SW) begin
        next_st.cs_fld = apb.pwdata[windowed_watchdog_pkg::C1_CS_LSB +: 3];
      end
      if (cfg.win == windowed_watchdog_pkg::WIN_CFG_SW) begin
        next_st.win_fld = apb.pwdata[windowed_watchdog_pkg::C1_WIN_LSB +: 3];
      end
    end
    if (wr_lane && sel_fl) begin
      next_st.wv_flag = apb.pwdata[windowed_watchdog_pkg::FL_WV_BIT];
      next_st.rw_flag = apb.pwdata[windowed_watchdog_pkg::FL_RW_BIT];
    end

    // hardware clears win over a firmware write
    // violation clears its flag
    if (viol) begin
      next_st.wv_flag = 1'b0;
    end
    if (tout && !in_sleep) begin
      next_st.rw_flag = 1'b0;
    end

    if (sleep_enter) begin
      next_st.pwrdn_n = 1'b0;
    end
    if (tout && in_sleep) begin
      next_st.to_n = 1'b0;
    end
    if (valid_clr) begin
      next_st.to_n = 1'b1;
      next_st.pwrdn_n = 1'b1;
    end

    // device reset restores default fields, two second period
    if (dev_rst) begin
      next_st.sw_en   = 1'b0;
      next_st.ps_fld  = windowed_watchdog_pkg::PS_RST;
      next_st.cs_fld  = windowed_watchdog_pkg::CS_RST;
      next_st.win_fld = windowed_watchdog_pkg::WIN_RST;
    end

    // snapshot of read data for the access phase
    if (setup) begin
      next_st.rdata = rd_val;
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_RST;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs
  assign prdata                = st.rdata;
  assign pready                = 1'b1;
  assign pslverr               = acc & ~hit;
  assign wdt_reset_req         = st.rst_req;
  assign wake_req              = st.wake;
  assign timeout_status_n      = st.to_n;
  assign powerdown_status_n    = st.pwrdn_n;
  assign window_violation_flag = st.wv_flag;
  assign watchdog_reset_flag   = st.rw_flag;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_mode_off_idle: assert property (
    clk_en && cfg.mode == windowed_watchdog_pkg::MODE_OFF |=> st.pre_cnt == '0 && st.tmr == '0)
    else $error("counter moved with watchdog off");

  a_sleep_stops: assert property (
    clk_en && cfg.mode == windowed_watchdog_pkg::MODE_NOSLP && in_sleep |=> st.tmr == '0 && !st.armed)
    else $error("counter moved in sleep with mode 10");

  a_sleep_wake: assert property (
    clk_en && tout && in_sleep |=> wake_req && !wdt_reset_req && !timeout_status_n)
    else $error("sleep time-out did not wake");

  a_viol_reset: assert property (
    clk_en && viol |=> wdt_reset_req && !window_violation_flag)
    else $error("violation did not reset");

  a_unarmed_clear: assert property (
    clk_en && clear_instr && active && windowed && !st.armed
    |=> wdt_reset_req && !window_violation_flag)
    else $error("unarmed clear accepted");

  // closed while the top three counter bits sit below seven minus the code
  a_closed_window: assert property (
    clk_en && clear_instr && active && windowed && st.tmr[4:2] < (3'h7 - win_eff)
    |=> wdt_reset_req)
    else $error("clear in closed window accepted");

  a_tout_flag: assert property (
    clk_en && tout && !in_sleep |=> wdt_reset_req && !watchdog_reset_flag)
    else $error("time-out did not reset");

  a_write_clears: assert property (
    clk_en && ctrl_wr |=> st.pre_cnt == '0 && st.tmr == '0 && !st.armed)
    else $error("control write left counter running");

  a_arm_read: assert property (
    clk_en && rd_c0 ##1 clk_en && !cnt_clr ##1 clk_en && setup && sel_tmr |=> prdata[2])
    else $error("arming read not shown");

  a_ost_hold: assert property (
    clk_en && startup_busy [*2] |=> st.pre_cnt == '0 && st.tmr == '0)
    else $error("counter moved during start-up");

  c_tout_reset: cover property (clk_en && tout && !in_sleep);
  c_viol: cover property (clk_en && viol);
  c_sleep_wake: cover property (clk_en && tout && in_sleep);
  c_valid_clr: cover property (clk_en && valid_clr && windowed);

endmodule : windowed_watchdog_top

`default_nettype wire

// File: bench/tb_windowed_watchdog_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_windowed_watchdog_top;
  localparam int LF_T = 8;
  localparam int MF_T = 12;
  localparam logic [15:0] A_C0  = {windowed_watchdog_pkg::IDX_CTRL0, 2'b00};
  localparam logic [15:0] A_C1  = {windowed_watchdog_pkg::IDX_CTRL1, 2'b00};
  localparam logic [15:0] A_PSL = {windowed_watchdog_pkg::IDX_PSL, 2'b00};
  localparam logic [15:0] A_PSH = {windowed_watchdog_pkg::IDX_PSH, 2'b00};
  localparam logic [15:0] A_TMR = {windowed_watchdog_pkg::IDX_TMR, 2'b00};
  localparam logic [15:0] A_FL  = {windowed_watchdog_pkg::IDX_FLAGS, 2'b00};
  localparam logic [15:0] A_BAD = A_FL + 16'h0004;

  logic                clock       = 1'b0;
  logic                sys_rst     = 1'b1;
  logic                clk_en      = 1'b1;
  logic                dev_rst     = 1'b0;
  windowed_watchdog_pkg::windowed_watchdog_cfg_t cfg         = '{mode: 2'h0, cs: 3'h7, ps: 5'h1f, win: 3'h7};
  logic                lf_osc_clk  = 1'b0;
  logic                mf_osc_clk  = 1'b0;
  logic                in_sleep    = 1'b0;
  logic                startup_busy = 1'b0;
  logic                clear_instr = 1'b0;
  windowed_watchdog_pkg::windowed_watchdog_apb_t apb         = '0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                wdt_reset_req;
  logic                wake_req;
  logic                timeout_status_n;
  logic                powerdown_status_n;
  logic                window_violation_flag;
  logic                watchdog_reset_flag;
  int                  n_fail    = 0;
  int                  cmp_count = 0;
  int                  n_req     = 0;
  int                  n_wk      = 0;
  int                  lf_div    = 0;
  int                  mf_div    = 0;
  int                  n;
  int                  r0;
  logic [31:0]         q;
  logic                e;
  logic [31:0]         c0_tab [4] = '{32'h01, 32'h03, 32'h27, 32'h01};
  logic [31:0]         c1_tab [4] = '{32'h07, 32'h07, 32'h07, 32'h17};
  int                  ex_tab [4] = '{32 * LF_T, 64 * LF_T, 32 * LF_T, 32 * MF_T};

  windowed_watchdog_top windowed_watchdog_top_inst (
    .clock                 (clock),
    .sys_rst               (sys_rst),
    .clk_en                (clk_en),
    .dev_rst               (dev_rst),
    .cfg                   (cfg),
    .lf_osc_clk            (lf_osc_clk),
    .mf_osc_clk            (mf_osc_clk),
    .in_sleep              (in_sleep),
    .startup_busy          (startup_busy),
    .clear_instr           (clear_instr),
    .apb                   (apb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .wdt_reset_req         (wdt_reset_req),
    .wake_req              (wake_req),
    .timeout_status_n      (timeout_status_n),
    .powerdown_status_n    (powerdown_status_n),
    .window_violation_flag (window_violation_flag),
    .watchdog_reset_flag   (watchdog_reset_flag)
  );

  // system clock, 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end

  // sped-up oscillators: a tick every 8 and every 12 cycles
  always @(posedge clock) begin
    lf_div <= (lf_div == LF_T / 2 - 1) ? 0 : lf_div + 1;
    mf_div <= (mf_div == MF_T / 2 - 1) ? 0 : mf_div + 1;
    if (lf_div == LF_T / 2 - 1) lf_osc_clk <= ~lf_osc_clk;
    if (mf_div == MF_T / 2 - 1) mf_osc_clk <= ~mf_osc_clk;
  end

  // counts reset and wake pulses
  always @(posedge clock) begin
    if (wdt_reset_req === 1'b1) n_req <= n_req + 1;
    if (wake_req === 1'b1) n_wk <= n_wk + 1;
  end

  task close_out;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one apb transfer, held until pready at a rising edge
  task xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
    @(posedge clock);
    apb.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("pready wait", 32'h1, 32'h0);
      close_out();
    end
    q = prdata;
    e = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer

  task rd(input logic [15:0] a, input logic [31:0] ex, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, ex, q);
  endtask : rd

  task wr(input logic [15:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task pulse_clr;
    @(posedge clock);
    clear_instr <= 1'b1;
    @(posedge clock);
    clear_instr <= 1'b0;
  endtask : pulse_clr

  // waits for a reset or wake pulse and checks its cycle count
  task wait_ev(input logic wk, input int lo, input int hi, input string nm);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while ((wk ? wake_req : wdt_reset_req) !== 1'b1 && k <= hi);
    chk(nm, 32'h1, {31'h0, (k >= lo) && (k <= hi)});
    if (k > hi) close_out();
  endtask : wait_ev

  task quiet(input int cyc, input string nm);
    int r;
    r = n_req + n_wk;
    repeat (cyc) @(posedge clock);
    chk(nm, 32'(r), 32'(n_req + n_wk));
  endtask : quiet

  task do_reset(input logic [1:0] md, input logic [4:0] ps);
    @(posedge clock);
    sys_rst <= 1'b1;
    cfg <= '{mode: md, cs: 3'h7, ps: ps, win: 3'h7};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset

  initial begin
    do_reset(2'h0, 5'h1f);
    rd(A_C0, {26'h0, windowed_watchdog_pkg::PS_RST, 1'b0}, "ctrl0 reset");
    rd(A_C1, {25'h0, windowed_watchdog_pkg::CS_RST, 1'b0, windowed_watchdog_pkg::WIN_RST}, "ctrl1 reset");
    rd(A_TMR, 32'h0, "tmr reset");
    rd(A_FL, 32'hf, "flags reset");
    rd(A_BAD, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(A_TMR, 32'hff);
    rd(A_TMR, 32'h0, "tmr read only");
    pulse_clr();
    quiet(600, "mode off events");
    rd(A_PSL, 32'h0, "psl off");
    rd(A_PSH, 32'h0, "psh off");
    // time-out period per code and clock
    do_reset(2'h1, 5'h1f);
    for (int i = 0; i < 4; i++) begin
      wr(A_C1, c1_tab[i]);
      wr(A_C0, c0_tab[i]);
      wait_ev(1'b0, ex_tab[i] - 16, ex_tab[i] + 16, "timeout cycles");
    end
    chk("reset flag", 32'h0, {31'h0, watchdog_reset_flag});
    // device reset restores fields, flags kept
    @(posedge clock);
    dev_rst <= 1'b1;
    @(posedge clock);
    dev_rst <= 1'b0;
    rd(A_C0, {26'h0, windowed_watchdog_pkg::PS_RST, 1'b0}, "ctrl0 dev reset");
    rd(A_FL, 32'hd, "flags after timeout");
    wr(A_FL, 32'h3);
    rd(A_FL, 32'hf, "flags rewritten");
    // window 000, clears without arming and too early
    wr(A_C1, 32'h00);
    wr(A_C0, 32'h01);
    pulse_clr();
    repeat (3) @(posedge clock);
    chk("wv flag unarmed", 32'h0, {31'h0, window_violation_flag});
    wr(A_FL, 32'h3);
    r0 = n_req;
    rd(A_C0, 32'h01, "ctrl0 arm read");
    pulse_clr();
    repeat (3) @(posedge clock);
    chk("closed window reset", 32'(r0 + 1), 32'(n_req));
    wr(A_FL, 32'h3);
    // armed clear inside the last eighth
    n = 0;
    do begin
      xfer(A_TMR, 1'b0, 32'h0);
      n++;
    end while (q[7:3] < 5'd28 && n < 200);
    chk("armed before", 32'h0, {31'h0, q[2]});
    xfer(A_C0, 1'b0, 32'h0);
    xfer(A_TMR, 1'b0, 32'h0);
    chk("armed after read", 32'h1, {31'h0, q[2]});
    r0 = n_req;
    pulse_clr();
    xfer(A_TMR, 1'b0, 32'h0);
    chk("open window clear", 32'(r0), 32'(n_req));
    chk("tmr after clear", 32'h0, {29'h0, q[7:6], q[2]});
    wr(A_C0, 32'h00);
    quiet(600, "software disabled");
    // locked prescale, always on, time-out in sleep
    do_reset(2'h3, 5'h00);
    wr(A_C0, 32'h3e);
    rd(A_C0, 32'h00, "locked prescale");
    @(posedge clock);
    in_sleep <= 1'b1;
    r0 = n_req;
    wait_ev(1'b1, 32 * LF_T - 16, 32 * LF_T + 16, "sleep wake");
    chk("no reset in sleep", 32'(r0), 32'(n_req));
    @(posedge clock);
    chk("status after wake", 32'h0, {30'h0, timeout_status_n, powerdown_status_n});
    @(posedge clock);
    in_sleep <= 1'b0;
    startup_busy <= 1'b1;
    quiet(600, "start-up hold");
    @(posedge clock);
    startup_busy <= 1'b0;
    pulse_clr();
    @(posedge clock);
    chk("status after clear", 32'h3, {30'h0, timeout_status_n, powerdown_status_n});
    // clock enable low freezes the count, so the period resumes from the held count after it
    clk_en <= 1'b0;
    repeat (100) @(posedge clock);
    clk_en <= 1'b1;
    wait_ev(1'b0, 32 * LF_T - 16, 32 * LF_T + 16, "always on awake");
    // off in sleep, on when awake
    do_reset(2'h2, 5'h00);
    @(posedge clock);
    in_sleep <= 1'b1;
    quiet(600, "off in sleep");
    @(posedge clock);
    in_sleep <= 1'b0;
    wait_ev(1'b0, 32 * LF_T - 16, 32 * LF_T + 16, "on when awake");
    close_out();
  end

endmodule : tb_windowed_watchdog_top

`default_nettype wire
